// file: src/vpic_controller.sv
// Vectored priority interrupt controller, top level
//
// Behaviour
// - All interrupt lines merge into one request toward the core.
// - Primary table starts at 0x000004, 126 vectors: 8 traps, 118 sources.
// - Each vector is read as a 24-bit service routine start address.
// - Alternate-table select bit 15 redirects every vector fetch to the alternate table.
// - Alternate table has same layout at 0x000104, two addresses per vector.
// - Reset bypasses this block; it only clears its registers, PC starts at zero.
// - Only oscillator, address, stack, math, ext0, timer, serial, converter vectors are live.
// - Sixteen CPU levels; a source is taken only above the current level.
// - Levels 8-15 belong to fixed traps; user sources span levels 0-7.
// - A level-0 source is never serviced.
// - CPU level is status bits 7:5 plus core control bit 3.
// - Software writes the three-bit level; 111 blocks all user sources.
// - Trap bit set by hardware on trap entry; software may only clear it.
// - With nesting disabled the three-bit level ignores software writes.
// - Source level is low three bits of each nibble; top bit ignored.
// - User levels 1 to 7; an all-zero field disables the source.
// - Equal levels resolve to the lowest vector number.
// - A running exception is preempted only by a strictly higher level.
`timescale 1ns/10ps
`include "vpic_defs.svh"
module vpic_controller
	import vpic_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [`VPIC_NUM_VEC-1:0] irqLines,
	input wire logic [`VPIC_NUM_VEC*`VPIC_NIB_W-1:0] sourcePriorityRegs,
	input wire logic [15:0] interruptControlTwo,
	input wire logic nestingDisable,
	input wire logic statusWrite,
	input wire logic [2:0] statusWrData,
	input wire logic trapBitClear,
	input wire logic exceptionReturn,
	input wire vpic_lvl_t restoreLevel,
	input wire logic irqAck,
	input wire logic [`VPIC_ADDR_W-1:0] fetchData,
	output logic irqRequest,
	output vpic_grant_s irqGrant,
	output logic fetchStrobe,
	output logic [`VPIC_ADDR_W-1:0] vectorFetchAddr,
	output logic serviceValid,
	output logic [`VPIC_ADDR_W-1:0] serviceRoutineAddr,
	output logic [15:0] cpuStatusReg,
	output logic [15:0] coreControlReg
);
	vpic_state_e state;
	vpic_state_e next_state;
	logic [`VPIC_NUM_VEC*`VPIC_LVL_W-1:0] levelVector;
	logic winFound;
	vpic_grant_s winGrant;
	logic [`VPIC_ADDR_W-1:0] tableAddr;
	logic altTableLatch;

	wire [2:0] cpuPriorityField;
	wire cpuTrapPriorityBit;
	wire vpic_lvl_t cpuLevel;
	wire altTableSelect;
	wire [`VPIC_NUM_VEC-1:0] liveMask;
	wire [`VPIC_NUM_VEC-1:0] pendingLines;
	wire wantRequest;
	wire accept;
	wire swFieldWrite;

	// Current CPU level from the two status registers
	assign cpuPriorityField = cpuStatusReg[`VPIC_PRIO_LSB +: 3];
	assign cpuTrapPriorityBit = coreControlReg[`VPIC_TRAP_BIT_POS];
	assign cpuLevel = {cpuTrapPriorityBit, cpuPriorityField};
	assign altTableSelect = interruptControlTwo[`VPIC_ALT_SEL_BIT];

	// Per-vector effective level: traps fixed high, user sources from nibbles
	genvar gi;
	generate
		for (gi = 0; gi < `VPIC_NUM_VEC; gi++) begin : g_level
			if (gi < `VPIC_NUM_TRAP) begin : g_trap
				// Each trap owns one fixed level, the first trap the highest
				assign levelVector[gi*`VPIC_LVL_W +: `VPIC_LVL_W] =
					`VPIC_TOP_LEVEL - vpic_lvl_t'(gi);
				assign liveMask[gi] = 1'b1;
			end else begin : g_user
				// Only the low three bits count, so a user level never passes 7
				assign levelVector[gi*`VPIC_LVL_W +: `VPIC_LVL_W] =
					{1'b0, sourcePriorityRegs[gi*`VPIC_NIB_W +: 3]};
				// A zero field keeps the source out of arbitration
				assign liveMask[gi] = |sourcePriorityRegs[gi*`VPIC_NIB_W +: 3];
			end
		end
	endgenerate

	// Reserved vectors never take part
	assign pendingLines = irqLines & liveMask & `VPIC_IMPL_MASK;

	vpic_prio_tree u_prio_tree (
		.pending(pendingLines),
		.levels(levelVector),
		.found(winFound),
		.winner(winGrant)
	);

	// Strictly above the CPU level; same-level arrivals wait for the current one
	assign wantRequest = winFound && (winGrant.level > cpuLevel);
	assign accept = irqRequest && irqAck;
	assign swFieldWrite = statusWrite && !nestingDisable;

	vpic_vector_addr u_vector_addr (
		.vector(irqGrant.vector),
		.altSelect(altTableLatch),
		.fetchAddr(tableAddr)
	);

	// Next state of the vector fetch sequence
	always_comb begin
		next_state = state;
		case (state)
			VPIC_IDLE: begin
				if (accept) begin
					next_state = VPIC_FETCH;
				end
			end
			VPIC_FETCH: begin
				next_state = VPIC_LOAD;
			end
			VPIC_LOAD: begin
				next_state = VPIC_IDLE;
			end
			default: begin
				next_state = VPIC_IDLE;
			end
		endcase
	end

	// Single merged request and the grant shown with it
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= VPIC_IDLE;
			irqRequest <= 1'b0;
			irqGrant <= '0;
			altTableLatch <= 1'b0;
		end else begin
			state <= next_state;
			irqRequest <= (next_state == VPIC_IDLE) && !accept && wantRequest;
			if (!irqRequest || !irqAck) begin
				irqGrant <= winGrant;
			end
			if (accept) begin
				altTableLatch <= altTableSelect;
			end
		end
	end

	// Vector fetch: address out, then the 24-bit entry comes back
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fetchStrobe <= 1'b0;
			vectorFetchAddr <= `VPIC_RESET_PC;
			serviceValid <= 1'b0;
			serviceRoutineAddr <= `VPIC_RESET_PC;
		end else begin
			fetchStrobe <= (state == VPIC_IDLE) && accept;
			serviceValid <= (state == VPIC_LOAD);
			if (state == VPIC_FETCH) begin
				vectorFetchAddr <= tableAddr;
			end
			if (state == VPIC_LOAD) begin
				serviceRoutineAddr <= fetchData;
			end
		end
	end

	// Three-bit CPU level: entry loads the low bits of the granted level, return restores, software writes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cpuStatusReg <= 16'h0000;
		end else if (accept) begin
			cpuStatusReg[`VPIC_PRIO_LSB +: 3] <= irqGrant.level[2:0];
		end else if (exceptionReturn) begin
			cpuStatusReg[`VPIC_PRIO_LSB +: 3] <= restoreLevel[2:0];
		end else if (swFieldWrite) begin
			cpuStatusReg[`VPIC_PRIO_LSB +: 3] <= statusWrData;
		end
	end

	// Trap bit: hardware sets it on trap entry, software can only clear it
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			coreControlReg <= 16'h0000;
		end else if (accept) begin
			coreControlReg[`VPIC_TRAP_BIT_POS] <= irqGrant.level[3];
		end else if (exceptionReturn) begin
			coreControlReg[`VPIC_TRAP_BIT_POS] <= restoreLevel[3] & cpuTrapPriorityBit;
		end else if (trapBitClear) begin
			coreControlReg[`VPIC_TRAP_BIT_POS] <= 1'b0;
		end
	end

	// Checks on the controller's own outputs
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	sequence s_accept;
		(state == VPIC_IDLE) && accept;
	endsequence

	sequence s_fetch;
		fetchStrobe ##2 serviceValid;
	endsequence

	// A request is raised only for a winner above the CPU level
	req_above_cpu_a: assert property (
		irqRequest |-> ($past(winFound) && ($past(winGrant.level) > $past(cpuLevel))))
		else $error("request raised for a level not above the CPU level");

	// Level 0 sources never appear as a request
	zero_level_a: assert property (
		irqRequest |-> (irqGrant.level != 4'h0))
		else $error("level 0 source requested service");

	// User vectors never carry a trap level
	user_range_a: assert property (
		(irqRequest && (irqGrant.vector >= 7'h08)) |-> (irqGrant.level <= `VPIC_USER_MAX))
		else $error("user source above level 7");

	// Acceptance raises the CPU level to the granted level
	accept_raise_a: assert property (
		accept |=> (cpuLevel == $past(irqGrant.level)))
		else $error("CPU level not raised on acceptance");

	// Acceptance leads to a table fetch and then a service address
	fetch_seq_a: assert property (
		s_accept |=> s_fetch ##0 (serviceRoutineAddr == $past(fetchData)))
		else $error("vector fetch sequence broken");

	// Fetch address follows the table chosen at acceptance
	table_addr_a: assert property (
		s_accept |=> ##1 (vectorFetchAddr == (($past(altTableSelect, 2) ? `VPIC_ALTERNATE_VECTOR_TABLE_BASE
			: `VPIC_IVT_BASE) + {16'h0000, $past(irqGrant.vector, 2), 1'b0})))
		else $error("wrong vector table address");

	// Software alone never sets the trap bit
	trap_bit_a: assert property (
		$rose(cpuTrapPriorityBit) |-> $past(accept && irqGrant.level[3]))
		else $error("trap bit set without trap entry");

	// Field holds against software writes while nesting is disabled
	nest_lock_a: assert property (
		(nestingDisable && statusWrite && !accept && !exceptionReturn) |=> $stable(cpuPriorityField))
		else $error("level field written while nesting disabled");

	// No second request while a fetch sequence runs
	single_req_a: assert property (
		accept |=> !irqRequest [*2])
		else $error("request during vector fetch");

	// Reset clears the request, the CPU level and the fetch state
	reset_clear_a: assert property (
		@(posedge clk) disable iff (1'b0)
		sys_rst |=> (!irqRequest && (cpuLevel == 4'h0) && (state == VPIC_IDLE)))
		else $error("registers not cleared by reset");

	// A request only ever names a vector from 1 to 73
	grant_live_a: assert property (
		irqRequest |-> ((irqGrant.vector != 7'h00) && (irqGrant.vector < 7'h4a)))
		else $error("request for a reserved vector");

	// Trap vectors carry their own fixed level
	trap_level_a: assert property (
		(irqRequest && (irqGrant.vector < 7'h08)) |-> (irqGrant.level == (4'hf - irqGrant.vector[3:0])))
		else $error("trap level not fixed by its position");

	// Fetch strobe lasts one cycle and only in the fetch state
	strobe_pulse_a: assert property (
		fetchStrobe |-> ((state == VPIC_FETCH) ##1 !fetchStrobe))
		else $error("fetch strobe out of place");

	// Service address is flagged for one cycle, back in idle
	valid_pulse_a: assert property (
		serviceValid |-> ((state == VPIC_IDLE) ##1 !serviceValid))
		else $error("service valid out of place");

	// Grant stays put in the acceptance cycle
	grant_hold_a: assert property (
		accept |=> (irqGrant == $past(irqGrant)))
		else $error("grant changed at acceptance");

	// Software clear takes the trap bit down
	trap_clear_a: assert property (
		(trapBitClear && !accept && !exceptionReturn) |=> !cpuTrapPriorityBit)
		else $error("trap bit not cleared");

	// Software write lands when nesting is allowed
	sw_write_a: assert property (
		(swFieldWrite && !accept && !exceptionReturn) |=> (cpuPriorityField == $past(statusWrData)))
		else $error("software level write lost");

	// Return restores the three-bit level
	return_level_a: assert property (
		(exceptionReturn && !accept) |=> (cpuPriorityField == $past(restoreLevel[2:0])))
		else $error("level not restored on return");

	// Field at 111 lets only traps through
	block_all_a: assert property (
		(cpuPriorityField == 3'h7) |=> (!irqRequest || irqGrant.level[3]))
		else $error("user source taken with field at 111");

	// Unused status bits stay at zero
	spare_bits_a: assert property (
		((cpuStatusReg & 16'hff1f) == 16'h0000) && ((coreControlReg & 16'hfff7) == 16'h0000))
		else $error("spare status bits set");

	// Table choice is taken at acceptance
	alt_latch_a: assert property (
		accept |=> (altTableLatch == $past(altTableSelect)))
		else $error("table select not latched");

	// Load state always falls back to idle
	load_idle_a: assert property (
		(state == VPIC_LOAD) |=> (state == VPIC_IDLE))
		else $error("fetch sequence did not end");

	// Without acceptance the sequence never starts
	no_accept_a: assert property (
		((state == VPIC_IDLE) && !accept) |=> (state == VPIC_IDLE))
		else $error("fetch started without acceptance");

	// Fetch address holds while the service address is shown
	addr_hold_a: assert property (
		serviceValid |-> $stable(vectorFetchAddr))
		else $error("fetch address moved early");

	// An accepted source always lifts the CPU above level 0
	level_up_a: assert property (
		accept |=> (cpuLevel != 4'h0))
		else $error("CPU level zero after acceptance");

	// Next acceptance only from idle
	accept_idle_a: assert property (
		accept |-> (state == VPIC_IDLE))
		else $error("acceptance outside idle");
endmodule

// file: src/vpic_defs.svh
// Constants of the vectored priority interrupt controller
`ifndef VPIC_DEFS_SVH
`define VPIC_DEFS_SVH

`define VPIC_NUM_VEC 126
`define VPIC_NUM_TRAP 8
`define VPIC_VEC_W 7
`define VPIC_LVL_W 4
`define VPIC_ADDR_W 24
`define VPIC_IVT_BASE 24'h000004
`define VPIC_ALTERNATE_VECTOR_TABLE_BASE 24'h000104
`define VPIC_RESET_PC 24'h000000
`define VPIC_ALT_SEL_BIT 15
`define VPIC_PRIO_LSB 5
`define VPIC_TRAP_BIT_POS 3
`define VPIC_TOP_LEVEL 4'hf
`define VPIC_USER_MAX 4'h7
`define VPIC_NIB_W 4

// Implemented sources; every other vector number is reserved
`define VPIC_VEC_OSC_FAIL 7'h01
`define VPIC_VEC_ADDR_ERR 7'h02
`define VPIC_VEC_STACK_ERR 7'h03
`define VPIC_VEC_MATH_ERR 7'h04
`define VPIC_VEC_EXT_ZERO 7'h08
`define VPIC_VEC_TIMER_ONE 7'h0b
`define VPIC_VEC_SERIAL_RX 7'h13
`define VPIC_VEC_SERIAL_TX 7'h14
`define VPIC_VEC_CONV_DONE 7'h15
`define VPIC_VEC_SERIAL_ERR 7'h49
`define VPIC_IMPL_MASK 126'h200000000000038091e

`endif

// file: src/vpic_pkg.sv
// Types shared by the interrupt controller modules
package vpic_pkg;
	typedef logic [6:0] vpic_vec_t;
	typedef logic [3:0] vpic_lvl_t;

	// Winning source and its level, travel together to the core
	typedef struct packed {
		vpic_vec_t vector;
		vpic_lvl_t level;
	} vpic_grant_s;

	typedef enum logic [1:0] {
		VPIC_IDLE,
		VPIC_FETCH,
		VPIC_LOAD
	} vpic_state_e;
endpackage

// file: src/vpic_prio_tree.sv
// Priority resolver: highest level first, then lowest vector number
`timescale 1ns/10ps
`include "vpic_defs.svh"
module vpic_prio_tree
	import vpic_pkg::*;
(
	input wire logic [`VPIC_NUM_VEC-1:0] pending,
	input wire logic [`VPIC_NUM_VEC*`VPIC_LVL_W-1:0] levels,
	output logic found,
	output vpic_grant_s winner
);
	// Scan from the highest vector down; ties move toward the lower number
	always_comb begin
		found = 1'b0;
		winner = '0;
		for (int i = `VPIC_NUM_VEC - 1; i >= 0; i--) begin
			if (pending[i] && (!found || levels[i*`VPIC_LVL_W +: `VPIC_LVL_W] >= winner.level)) begin
				found = 1'b1;
				winner.vector = vpic_vec_t'(i);
				winner.level = levels[i*`VPIC_LVL_W +: `VPIC_LVL_W];
			end
		end
	end
endmodule

// file: src/vpic_vector_addr.sv
// Vector table address for a vector number in either table
`timescale 1ns/10ps
`include "vpic_defs.svh"
module vpic_vector_addr
	import vpic_pkg::*;
(
	input wire vpic_vec_t vector,
	input wire logic altSelect,
	output logic [`VPIC_ADDR_W-1:0] fetchAddr
);
	wire [`VPIC_ADDR_W-1:0] tableBase;
	wire [`VPIC_ADDR_W-1:0] vecOffset;

	// Same layout in both tables, two addresses per vector
	assign tableBase = altSelect ? `VPIC_ALTERNATE_VECTOR_TABLE_BASE : `VPIC_IVT_BASE;
	assign vecOffset = {16'h0000, vector, 1'b0};
	assign fetchAddr = tableBase + vecOffset;
endmodule

// file: test/tb_vpic_controller.sv
// Self-checking bench for the vectored priority interrupt controller
`timescale 1ns/10ps
`include "vpic_defs.svh"
module tb_vpic_controller
	import vpic_pkg::*;
;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [`VPIC_NUM_VEC-1:0] irqLines = '0;
	logic [`VPIC_NUM_VEC*`VPIC_NIB_W-1:0] prio = '0;
	logic [15:0] ctl = 16'h0000;
	logic nestingDisable = 1'b0;
	logic statusWrite = 1'b0;
	logic trapBitClear = 1'b0;
	logic exceptionReturn = 1'b0;
	logic [2:0] statusWrData = 3'h0;
	vpic_lvl_t restoreLevel = 4'h0;
	logic [3:0] ackDelay = 4'h0;
	logic irqAck, irqRequest, fetchStrobe, serviceValid;
	logic [23:0] fetchData, vectorFetchAddr, serviceRoutineAddr;
	logic [15:0] cpuStatusReg, coreControlReg;
	vpic_grant_s irqGrant, gotGrant;
	logic [38:0] q[$];
	int errors = 0;
	int samples_checked = 0;
	int srcs[6] = '{8, 11, 19, 20, 21, 73};
	logic [31:0] seed = 32'h89e6;
	logic [31:0] r;
	wire [3:0] cpuLvl = {coreControlReg[3], cpuStatusReg[7:5]};

	// Clock at 100 MHz
	initial forever #5 clk = ~clk;

	vpic_controller dut (.clk, .sys_rst, .irqLines, .sourcePriorityRegs(prio),
		.interruptControlTwo(ctl), .nestingDisable, .statusWrite, .statusWrData,
		.trapBitClear, .exceptionReturn, .restoreLevel, .irqAck, .fetchData, .irqRequest,
		.irqGrant, .fetchStrobe, .vectorFetchAddr, .serviceValid, .serviceRoutineAddr,
		.cpuStatusReg, .coreControlReg);
	vpic_core_model core (.clk, .irqRequest, .fetchStrobe, .vectorFetchAddr, .ackDelay,
		.irqAck, .fetchData);

	// Helpers: random source, table contents, comparisons, verdict
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [23:0] tbl(input logic [23:0] a);
		return {a[11:0], ~a[11:0]};
	endfunction
	task automatic chk(input logic [38:0] got, input logic [38:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
		chk({35'h0, got}, {35'h0, exp});
	endtask
	task automatic test_done();
		if (errors == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Raise a source and note the grant, handler and CPU level it must yield
	task automatic raise(input int n, input logic [3:0] lvl, input logic alt);
		logic [3:0] el;
		logic [23:0] base;
		r = xs();
		el = n < 8 ? 4'(15 - n) : lvl;
		base = alt ? `VPIC_ALTERNATE_VECTOR_TABLE_BASE : `VPIC_IVT_BASE;
		prio[4*n +: 4] = {r[3], lvl[2:0]};
		ctl[15] = alt;
		ackDelay = {2'b00, r[5:4]};
		irqLines[n] = 1'b1;
		q.push_back({7'(n), el, tbl(base + 24'(2 * n)), el});
	endtask
	task automatic quiet();
		repeat (6) begin
			@(negedge clk);
			chk4({3'h0, irqRequest}, 4'h0);
		end
	endtask
	task automatic waitSvc();
		int i;
		i = 0;
		while (i < 60 && serviceValid !== 1'b1) begin
			@(posedge clk);
			i++;
		end
		if (i == 60) chk(39'h0, 39'h1);
	endtask
	task automatic doReturn(input logic [3:0] ret);
		@(negedge clk);
		exceptionReturn = 1'b1;
		restoreLevel = ret;
		@(negedge clk);
		exceptionReturn = 1'b0;
	endtask
	task automatic take(input int n, input logic [3:0] ret);
		waitSvc();
		@(negedge clk);
		irqLines[n] = 1'b0;
		quiet();
		doReturn(ret);
	endtask
	task automatic swWrite(input logic [2:0] d, input logic nd);
		@(negedge clk);
		statusWrite = 1'b1;
		statusWrData = d;
		nestingDisable = nd;
		@(negedge clk);
		statusWrite = 1'b0;
		nestingDisable = 1'b0;
	endtask

	// Scoreboard: each serviced exception is matched to the oldest note
	always @(posedge clk) begin
		if (irqRequest === 1'b1 && irqAck === 1'b1) gotGrant = irqGrant;
		if (serviceValid === 1'b1) begin
			if (q.size() > 0) chk({gotGrant, serviceRoutineAddr, cpuLvl}, q.pop_front());
			else chk(39'h0, 39'h1);
		end
	end

	// Watchdog
	initial begin
		#300000;
		errors++;
		test_done();
	end

	// Main sequence
	initial begin
		repeat (16) @(negedge clk);
		sys_rst = 1'b0;
		chk4(cpuLvl, 4'h0);
		chk({15'h0, vectorFetchAddr}, {15'h0, `VPIC_RESET_PC});
		quiet();
		raise(11, 4'h3, 1'b0);
		take(11, 4'h0);
		raise(8, 4'h5, 1'b0);
		raise(11, 4'h5, 1'b0);
		take(8, 4'h0);
		take(11, 4'h0);
		raise(73, 4'h7, 1'b0);
		raise(8, 4'h2, 1'b0);
		take(73, 4'h0);
		take(8, 4'h0);
		prio[84 +: 4] = 4'h8;
		prio[36 +: 4] = 4'h7;
		irqLines[21] = 1'b1;
		irqLines[9] = 1'b1;
		quiet();
		irqLines[21] = 1'b0;
		irqLines[9] = 1'b0;
		swWrite(3'h7, 1'b0);
		chk4(cpuLvl, 4'h7);
		prio[292 +: 4] = 4'h7;
		irqLines[73] = 1'b1;
		quiet();
		irqLines[73] = 1'b0;
		raise(4, 4'h0, 1'b0);
		waitSvc();
		@(negedge clk);
		irqLines[4] = 1'b0;
		trapBitClear = 1'b1;
		@(negedge clk);
		trapBitClear = 1'b0;
		chk4(cpuLvl, 4'h3);
		doReturn(4'h8);
		chk4(cpuLvl, 4'h0);
		swWrite(3'h3, 1'b0);
		swWrite(3'h5, 1'b1);
		chk4(cpuLvl, 4'h3);
		prio[44 +: 4] = 4'h3;
		irqLines[11] = 1'b1;
		quiet();
		irqLines[11] = 1'b0;
		raise(11, 4'h4, 1'b0);
		take(11, 4'h0);
		raise(19, 4'h6, 1'b1);
		take(19, 4'h0);
		repeat (6) begin
			int s;
			r = xs();
			s = srcs[r[7:0] % 6];
			raise(s, 4'(r[10:8] % 3'd7) + 4'h1, r[12]);
			take(s, 4'h0);
		end
		test_done();
	end
endmodule

// file: test/vpic_core_model.sv
// Behavioural model of the core and its vector table memory
`timescale 1ns/10ps
module vpic_core_model (
	input wire logic clk,
	input wire logic irqRequest,
	input wire logic fetchStrobe,
	input wire logic [23:0] vectorFetchAddr,
	input wire logic [3:0] ackDelay,
	output logic irqAck,
	output logic [23:0] fetchData
);
	logic [3:0] waitCnt = 4'h0;
	logic window = 1'b0;
	// Every table slot holds some handler address, reserved ones too
	function automatic logic [23:0] tbl(input logic [23:0] a);
		return {a[11:0], ~a[11:0]};
	endfunction
	// Acknowledge after a chosen stall, changed off the sampling edge
	always @(negedge clk) begin
		irqAck <= irqRequest && waitCnt >= ackDelay;
		waitCnt <= irqRequest ? waitCnt + 4'h1 : 4'h0;
	end
	// Memory word is valid only in the cycle after the strobe
	always @(posedge clk) window <= fetchStrobe;
	assign fetchData = window ? tbl(vectorFetchAddr) : ~tbl(vectorFetchAddr);
endmodule
